// *** common/ewt_pkg.sv ***
// Package: timing figures, bus-width codes and operation codes for the exception and walk timing block
// How it works
// - All clock figures assume each read or write bus cycle takes exactly two processor clocks.
// - A reported operation total already includes the clocks of its read, prefetch and write bus cycles.
// - Exception-related timings are complete execution times with no extra effective-address time.
// - A short bus-cycle fault save takes 36 clocks with one read and ten writes cached, 38 clocks plus two prefetches uncached.
// - A long bus-cycle fault save takes 62 clocks with one read and 24 writes cached, 64 clocks plus two prefetches uncached.
// - A return from exception with a four-word frame takes 18 clocks and four reads cached, 20 clocks plus two prefetches uncached.
// - Table-search time depends on tree shape, descriptor formats, used and modified flags and bus cycle time.
// - Nominal search timing assumes each descriptor access moves a full 32-bit word in one bus cycle.
// - With a 16-bit memory each descriptor access costs two bus cycle times.
// - With an 8-bit memory each descriptor access costs four bus cycle times.
// - The reported search time covers startup, descriptor fetches, flag updates and termination.
// - Setting a used flag is a locked read-modify-write, counted as one write beside the descriptor read.
package ewt_pkg;
   localparam int unsigned CNT_W         = 10;
   localparam int unsigned BUS_CLKS      = 2;
   // Fault and return figures (cached), uncached adds these
   localparam int unsigned SHORT_CLKS    = 36;
   localparam int unsigned SHORT_WR      = 10;
   localparam int unsigned LONG_CLKS     = 62;
   localparam int unsigned LONG_WR       = 24;
   localparam int unsigned RET_CLKS      = 18;
   localparam int unsigned RET_RD        = 4;
   localparam int unsigned FAULT_RD      = 1;
   localparam int unsigned NOCACHE_CLKS  = 2;
   localparam int unsigned NOCACHE_PF    = 2;
   // Walk overheads in clocks
   localparam int unsigned WALK_LEAD     = 7;
   localparam int unsigned WALK_START    = 8;
   localparam int unsigned WALK_FCL_SAVE = 2;
   localparam int unsigned WALK_TERM     = 8;
   localparam int unsigned LONG_BASE     = 6;
   localparam int unsigned LONG_PAGE_SAVE= 2;
   localparam int unsigned SHORT_BASE    = 3;
   localparam int unsigned PTR_U_BASE    = 4;
   localparam int unsigned PAGE_UM_BASE  = 2;
   localparam int unsigned IND_L_BASE    = 2;
   localparam int unsigned IND_S_BASE    = 3;
   localparam int unsigned ET_DELAY      = 3;
   localparam int unsigned OVL4          = 4;
   localparam int unsigned OVL3          = 3;
   typedef enum logic [1:0] {
      WIDTH_32 = 2'h0,
      WIDTH_16 = 2'h1,
      WIDTH_8  = 2'h2
   } ewt_width_type;
   typedef enum logic [1:0] {
      OP_SHORT_FAULT = 2'h0,
      OP_LONG_FAULT  = 2'h1,
      OP_RETURN      = 2'h2,
      OP_WALK        = 2'h3
   } ewt_op_type;
endpackage : ewt_pkg

// *** hw/ewt_walk_calc.sv ***
// Module: combinational clock and bus-cycle budget of one table search
`timescale 1ns/1ps
module ewt_walk_calc #(
   parameter int unsigned CW = ewt_pkg::CNT_W
) (
   input  wire logic                 fcl_i,
   input  wire logic [2:0]           n_long_i,
   input  wire logic [2:0]           n_short_i,
   input  wire logic                 ind_long_i,
   input  wire logic                 ind_short_i,
   input  wire logic [2:0]           ptr_ubits_i,
   input  wire logic                 page_um_i,
   input  wire logic                 early_term_i,
   input  wire logic                 long_page_i,
   input  wire ewt_pkg::ewt_width_type width_i,
   output logic      [CW-1:0]        clocks_o,
   output logic      [CW-1:0]        reads_o,
   output logic      [CW-1:0]        writes_o
);
   function automatic logic [CW-1:0] sat_sub(input logic [CW-1:0] a, input logic [CW-1:0] b);
      sat_sub = (a > b) ? a - b : '0;
   endfunction : sat_sub

   logic [CW-1:0] bus;
   logic [CW-1:0] m4;
   logic [CW-1:0] m3;
   logic [CW-1:0] l_clk;
   always_comb begin
      // Narrow ports scale the effective bus cycle time
      case (width_i)
         ewt_pkg::WIDTH_16: bus = CW'(2 * ewt_pkg::BUS_CLKS);
         ewt_pkg::WIDTH_8:  bus = CW'(4 * ewt_pkg::BUS_CLKS);
         default:           bus = CW'(ewt_pkg::BUS_CLKS);
      endcase
      m4 = sat_sub(bus, CW'(ewt_pkg::OVL4));
      m3 = sat_sub(bus, CW'(ewt_pkg::OVL3));
      l_clk = CW'(n_long_i) * (CW'(ewt_pkg::LONG_BASE) + bus + m4);
      if (long_page_i && (n_long_i != 3'h0)) begin
         l_clk = l_clk - CW'(ewt_pkg::LONG_PAGE_SAVE);
      end
      // Startup, fetches, flag updates and termination all summed
      clocks_o = CW'(ewt_pkg::WALK_LEAD) + CW'(ewt_pkg::WALK_START) + CW'(ewt_pkg::WALK_TERM)
               - (fcl_i ? CW'(ewt_pkg::WALK_FCL_SAVE) : '0)
               + l_clk
               + CW'(n_short_i) * (CW'(ewt_pkg::SHORT_BASE) + bus)
               + CW'(ptr_ubits_i) * (CW'(ewt_pkg::PTR_U_BASE) + m3)
               + (page_um_i ? CW'(ewt_pkg::PAGE_UM_BASE) + m3 : '0)
               + (ind_long_i ? CW'(ewt_pkg::IND_L_BASE) + (bus << 1) : '0)
               + ((ind_short_i && !ind_long_i) ? CW'(ewt_pkg::IND_S_BASE) + bus : '0)
               + (early_term_i ? CW'(ewt_pkg::ET_DELAY) : '0);
      // Each used-flag set is a locked read-modify-write: one write beside its read
      reads_o  = (CW'(n_long_i) << 1) + CW'(n_short_i)
               + (ind_long_i ? CW'(2) : (ind_short_i ? CW'(1) : '0));
      writes_o = CW'(ptr_ubits_i) + (page_um_i ? CW'(1) : '0);
   end
endmodule : ewt_walk_calc

// *** hw/ewt_core.sv ***
// Module: cycle-accurate busy/bus-cycle sequencer for fault save, return and table search
`timescale 1ns/1ps
module ewt_core #(
   parameter int unsigned CW = ewt_pkg::CNT_W
) (
   input  wire logic                   sys_clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   clk_en_i,
   input  wire logic                   start_i,
   input  wire ewt_pkg::ewt_op_type    op_i,
   input  wire logic                   cached_i,
   input  wire logic                   fcl_i,
   input  wire logic [2:0]             n_long_i,
   input  wire logic [2:0]             n_short_i,
   input  wire logic                   ind_long_i,
   input  wire logic                   ind_short_i,
   input  wire logic [2:0]             ptr_ubits_i,
   input  wire logic                   page_um_i,
   input  wire logic                   early_term_i,
   input  wire logic                   long_page_i,
   input  wire ewt_pkg::ewt_width_type width_i,
   output logic                        ready_o,
   output logic                        busy_o,
   output logic                        done_o,
   output logic [CW-1:0]               clocks_o,
   output logic [CW-1:0]               reads_o,
   output logic [CW-1:0]               prefetches_o,
   output logic [CW-1:0]               writes_o
);
   typedef enum logic {ST_IDLE, ST_RUN} ewt_state_type;
   typedef struct packed {
      ewt_state_type state;
      logic [CW-1:0] remain;
      logic          done;
      logic [CW-1:0] clocks;
      logic [CW-1:0] reads;
      logic [CW-1:0] prefetches;
      logic [CW-1:0] writes;
   } ewt_reg_type;

   ewt_reg_type r_q;
   ewt_reg_type r_d;
   logic [CW-1:0] w_clk;
   logic [CW-1:0] w_rd;
   logic [CW-1:0] w_wr;

   ewt_walk_calc #(.CW(CW)) u_walk (
      .fcl_i        (fcl_i),
      .n_long_i     (n_long_i),
      .n_short_i    (n_short_i),
      .ind_long_i   (ind_long_i),
      .ind_short_i  (ind_short_i),
      .ptr_ubits_i  (ptr_ubits_i),
      .page_um_i    (page_um_i),
      .early_term_i (early_term_i),
      .long_page_i  (long_page_i),
      .width_i      (width_i),
      .clocks_o     (w_clk),
      .reads_o      (w_rd),
      .writes_o     (w_wr)
   );

   always_comb begin
      logic [CW-1:0] c;
      logic [CW-1:0] rd;
      logic [CW-1:0] pf;
      logic [CW-1:0] wr;
      c  = '0;
      rd = '0;
      pf = '0;
      wr = '0;
      r_d = r_q;
      r_d.done = 1'b0;
      // Totals are complete: bus cycles included, no address time added
      case (op_i)
         ewt_pkg::OP_SHORT_FAULT: begin
            c  = CW'(ewt_pkg::SHORT_CLKS);
            rd = CW'(ewt_pkg::FAULT_RD);
            wr = CW'(ewt_pkg::SHORT_WR);
         end
         ewt_pkg::OP_LONG_FAULT: begin
            c  = CW'(ewt_pkg::LONG_CLKS);
            rd = CW'(ewt_pkg::FAULT_RD);
            wr = CW'(ewt_pkg::LONG_WR);
         end
         ewt_pkg::OP_RETURN: begin
            c  = CW'(ewt_pkg::RET_CLKS);
            rd = CW'(ewt_pkg::RET_RD);
         end
         default: begin
            c  = w_clk;
            rd = w_rd;
            wr = w_wr;
         end
      endcase
      if (!cached_i && (op_i != ewt_pkg::OP_WALK)) begin
         c  = c + CW'(ewt_pkg::NOCACHE_CLKS);
         pf = CW'(ewt_pkg::NOCACHE_PF);
      end
      case (r_q.state)
         ST_IDLE: begin
            if (start_i) begin
               r_d.state      = ST_RUN;
               r_d.remain     = (c > CW'(1)) ? c - CW'(1) : '0;
               r_d.clocks     = c;
               r_d.reads      = rd;
               r_d.prefetches = pf;
               r_d.writes     = wr;
               if (c <= CW'(1)) begin
                  r_d.state = ST_IDLE;
                  r_d.done  = 1'b1;
               end
            end
         end
         ST_RUN: begin
            r_d.remain = r_q.remain - CW'(1);
            if (r_q.remain == CW'(1)) begin
               r_d.state = ST_IDLE;
               r_d.done  = 1'b1;
            end
         end
         default: begin
            r_d.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_q <= '{state: ST_IDLE, default: '0};
      end else if (clk_en_i) begin
         r_q <= r_d;
      end
   end

   assign ready_o      = (r_q.state == ST_IDLE);
   assign busy_o       = (r_q.state == ST_RUN);
   assign done_o       = r_q.done;
   assign clocks_o     = r_q.clocks;
   assign reads_o      = r_q.reads;
   assign prefetches_o = r_q.prefetches;
   assign writes_o     = r_q.writes;
endmodule : ewt_core

// *** tb/ewt_core_asserts.sv ***
// Checker: port-level timing assertions of the sequencer
`timescale 1ns/1ps
module ewt_core_asserts #(
   parameter int unsigned CW = 10
) (
   input wire logic                sys_clk_i,
   input wire logic                arst_n_i,
   input wire logic                clk_en_i,
   input wire logic                start_i,
   input wire ewt_pkg::ewt_op_type op_i,
   input wire logic                cached_i,
   input wire logic                ready_o,
   input wire logic                busy_o,
   input wire logic                done_o,
   input wire logic [CW-1:0]       clocks_o,
   input wire logic [CW-1:0]       reads_o,
   input wire logic [CW-1:0]       prefetches_o,
   input wire logic [CW-1:0]       writes_o
);
   logic [CW-1:0] cnt_q;
   // Enabled edges since the taking edge
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) cnt_q <= '0;
      else if (clk_en_i && ready_o && start_i) cnt_q <= CW'(1);
      else if (clk_en_i && busy_o) cnt_q <= cnt_q + CW'(1);
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_take;
      clk_en_i && ready_o && start_i;
   endsequence
   property p_tot(ewt_pkg::ewt_op_type o, logic c, int ck, int rd, int pf, int wr);
      s_take ##0 (op_i == o && cached_i == c) |=>
         clocks_o == ck && reads_o == rd && prefetches_o == pf && writes_o == wr;
   endproperty
   short_cached_a: assert property (p_tot(ewt_pkg::OP_SHORT_FAULT, 1'b1, 36, 1, 0, 10)) else $error("short cached");
   short_nocache_a: assert property (p_tot(ewt_pkg::OP_SHORT_FAULT, 1'b0, 38, 1, 2, 10)) else $error("short");
   long_cached_a: assert property (p_tot(ewt_pkg::OP_LONG_FAULT, 1'b1, 62, 1, 0, 24)) else $error("long cached");
   long_nocache_a: assert property (p_tot(ewt_pkg::OP_LONG_FAULT, 1'b0, 64, 1, 2, 24)) else $error("long");
   ret_cached_a: assert property (p_tot(ewt_pkg::OP_RETURN, 1'b1, 18, 4, 0, 0)) else $error("return cached");
   ret_nocache_a: assert property (p_tot(ewt_pkg::OP_RETURN, 1'b0, 20, 4, 2, 0)) else $error("return");
   take_busy_a: assert property (s_take |=> busy_o && !ready_o) else $error("start not taken");
   done_count_a: assert property (done_o |-> cnt_q == clocks_o) else $error("duration differs");
   done_pulse_a: assert property (done_o && clk_en_i |=> !done_o) else $error("done too long");
   hold_totals_a: assert property (busy_o |=> $stable(clocks_o) && $stable(writes_o)) else $error("totals moved");
   freeze_state_a: assert property (!clk_en_i |=> $stable(busy_o) && $stable(cnt_q)) else $error("ran frozen");
endmodule : ewt_core_asserts
bind ewt_core ewt_core_asserts #(.CW(CW)) u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .clk_en_i(clk_en_i), .start_i(start_i), .op_i(op_i), .cached_i(cached_i), .ready_o(ready_o),
   .busy_o(busy_o), .done_o(done_o), .clocks_o(clocks_o), .reads_o(reads_o),
   .prefetches_o(prefetches_o), .writes_o(writes_o));

// *** tb/ewt_mem_model.sv ***
// Model: external memory pacing the core, prompt or with wait states
`timescale 1ns/1ps
module ewt_mem_model (
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   input  wire logic slow_i,
   output logic      clk_en_o
);
   // Slow memory drops the enable on every second clock, so each core clock takes two clocks
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) clk_en_o <= 1'b1;
      else clk_en_o <= slow_i ? ~clk_en_o : 1'b1;
   end
endmodule : ewt_mem_model

// *** tb/exception_and_walk_timing_tb.sv ***
// Testbench: self-checking run of the exception and walk timing core
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t got %0d exp %0d", $time, g, e); end end
module exception_and_walk_timing_tb;
   logic sys_clk_i = 0, arst_n_i = 0, clk_en, start = 0, cached = 1, slow = 0;
   logic fcl = 0, ind_l = 0, ind_s = 0, page_um = 0, et = 0, lpage = 0, ready, busy, done;
   logic [2:0] n_l = 0, n_s = 0, ptr_u = 0;
   ewt_pkg::ewt_op_type op = ewt_pkg::OP_SHORT_FAULT;
   ewt_pkg::ewt_width_type width = ewt_pkg::WIDTH_32;
   logic [9:0] clks, rds, pfs, wrs;
   int err_total = 0, n_tests = 0, e_clk, e_rd, e_pf, e_wr;
   ewt_mem_model mem (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .slow_i(slow), .clk_en_o(clk_en));
   ewt_core dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .start_i(start), .op_i(op),
      .cached_i(cached), .fcl_i(fcl), .n_long_i(n_l), .n_short_i(n_s), .ind_long_i(ind_l), .ind_short_i(ind_s),
      .ptr_ubits_i(ptr_u), .page_um_i(page_um), .early_term_i(et), .long_page_i(lpage), .width_i(width),
      .ready_o(ready), .busy_o(busy), .done_o(done), .clocks_o(clks), .reads_o(rds), .prefetches_o(pfs),
      .writes_o(wrs));
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   task automatic test_done();
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // Start one operation and judge duration and bus-cycle mix
   task automatic go(ewt_pkg::ewt_op_type o, logic c);
      int n;
      logic en;
      // The clock that takes the start is the first clock of the operation
      n = 1;
      @(posedge sys_clk_i);
      op <= o;
      cached <= c;
      start <= 1'b1;
      do begin #1 en = clk_en; @(posedge sys_clk_i); end while (en !== 1'b1);
      start <= 1'b0;
      do begin #1 en = clk_en; @(posedge sys_clk_i); n += int'(en); #1; end while (done !== 1'b1 && n < 2000);
      `CHK(n, e_clk)
      `CHK(clks, e_clk[9:0])
      `CHK(rds, e_rd[9:0])
      `CHK(pfs, e_pf[9:0])
      `CHK(wrs, e_wr[9:0])
   endtask : go
   task automatic t_fault(logic s);
      int ck[3] = '{36, 62, 18};
      int wr[3] = '{10, 24, 0};
      int rd[3] = '{1, 1, 4};
      slow <= s;
      for (int i = 0; i < 6; i++) begin
         e_clk = ck[i / 2] + 2 * (i % 2);
         e_pf = 2 * (i % 2);
         e_rd = rd[i / 2];
         e_wr = wr[i / 2];
         go(ewt_pkg::ewt_op_type'(i / 2), i % 2 == 0);
      end
      @(posedge sys_clk_i) slow <= 1'b0;
   endtask : t_fault
   task automatic t_walk();
      int b, m4, m3;
      for (int i = 0; i < 6; i++) begin
         b = i == 1 ? 4 : i == 2 ? 8 : 2;
         m4 = b > 4 ? b - 4 : 0;
         m3 = b > 3 ? b - 3 : 0;
         @(posedge sys_clk_i);
         // Last pass uses the spare width code, which runs as a full-width port
         width <= ewt_pkg::ewt_width_type'(i < 3 ? i : i == 5 ? 3 : 0);
         n_l <= 3'd2;
         n_s <= 3'(i > 2);
         fcl <= i == 3;
         ptr_u <= 3'(i == 3);
         page_um <= i > 2;
         ind_l <= i == 3;
         ind_s <= i == 4;
         et <= i == 4;
         lpage <= i == 4;
         e_clk = 23 - 2 * (i == 3) + 2 * (6 + b + m4) - 2 * (i == 4) + (i > 2) * (3 + b) + (i == 3) * (4 + m3)
            + (i > 2) * (2 + m3) + (i == 3 ? 2 + 2 * b : i == 4 ? 3 + b + 3 : 0);
         e_rd = 4 + (i > 2) + (i == 3 ? 2 : i == 4 ? 1 : 0);
         e_wr = (i == 3) + (i > 2);
         e_pf = 0;
         go(ewt_pkg::OP_WALK, i[0]);
      end
   endtask : t_walk
   // Start held high: refused while busy, taken again right after done
   task automatic t_busy();
      int n;
      n = 0;
      @(posedge sys_clk_i);
      op <= ewt_pkg::OP_SHORT_FAULT;
      cached <= 1'b1;
      start <= 1'b1;
      do begin @(posedge sys_clk_i); #1; end while (done !== 1'b1);
      // Retaken on the first edge after the done edge, then released on that same edge
      do begin @(posedge sys_clk_i); n++; if (n == 1) start <= 1'b0; #1; end while (done !== 1'b1 && n < 300);
      `CHK(n, 36)
   endtask : t_busy
   // Reset in mid-run: back to idle with cleared totals, then a fresh operation
   task automatic t_reset();
      @(posedge sys_clk_i);
      op <= ewt_pkg::OP_LONG_FAULT;
      cached <= 1'b1;
      start <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      start <= 1'b0;
      arst_n_i <= 1'b0;
      @(posedge sys_clk_i);
      #1 `CHK(busy, 1'b0)
      `CHK(ready, 1'b1)
      `CHK(clks, 10'h000)
      `CHK(wrs, 10'h000)
      @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      e_clk = 18;
      e_rd = 4;
      e_pf = 0;
      e_wr = 0;
      go(ewt_pkg::OP_RETURN, 1'b1);
   endtask : t_reset
   initial begin
      repeat (12) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      #1 `CHK(ready, 1'b1)
      t_fault(1'b0);
      t_fault(1'b1);
      t_walk();
      t_busy();
      t_reset();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      test_done();
   end
endmodule : exception_and_walk_timing_tb
